// file: src/rxals_pkg.sv
package rxals_pkg;

	// lane and field widths
	localparam int LANES = 4;
	localparam int INTERVAL_W = 16;
	localparam int BAD_CODE_W = 2;
	localparam int TP_ERR_W = 8;
	localparam int CONSEC_W = 3;
	localparam logic [CONSEC_W-1:0] REPEAT_LIMIT = 3'h4;

	// wishbone register byte offsets
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 4'h8;
	localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 4'hC;

	// control register layout
	localparam int CTRL_INTERVAL_LSB = 0;
	localparam int CTRL_TP_EN_BIT = 16;
	localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 16'h00FF;
	localparam logic CTRL_TP_EN_RESET = 1'b0;

	// status register layout
	localparam int STAT_ALIGNED_BIT = 0;
	localparam int STAT_HI_BER_BIT = 1;
	localparam int STAT_LINK_BIT = 2;
	localparam int STAT_ALIGN_LOSS_BIT = 3;
	localparam int STAT_EVER_ALIGNED_BIT = 4;
	localparam int STAT_REPEAT_LSB = 8;
	localparam int STAT_LOCKED_LSB = 12;

	// interrupt status and mask layout
	localparam int IRQ_W = 6;
	localparam int IRQ_MISALIGN_BIT = 0;
	localparam int IRQ_BIP_BIT = 1;
	localparam int IRQ_MARKER_WORD_BIT = 2;
	localparam int IRQ_BAD_CODE_BIT = 3;
	localparam int IRQ_TP_ERR_BIT = 4;
	localparam int IRQ_ALIGN_LOSS_BIT = 5;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

	// tracker for the delayed misalignment pulse
	typedef enum logic [1:0] {
		RXALS_NEVER = 2'b00,
		RXALS_ARMED = 2'b01,
		RXALS_PENDING = 2'b11
	} rxals_track_type;

endpackage

// file: src/rxals_lane.sv
`timescale 1ns/1ns
`default_nettype none

module rxals_lane (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// per lane receive events
	input wire logic word_valid_i,
	input wire logic marker_i,
	input wire logic marker_bad_i,
	input wire logic bip_mismatch_i,
	input wire logic [rxals_pkg::INTERVAL_W-1:0] marker_interval_minus_one_i,
	// per lane status
	output logic lane_marker_repeat_error_o,
	output logic lane_marker_word_error_o,
	output logic bip_error_o,
	output logic marker_error_o,
	output logic marker_good_seen_o,
	output logic locked_o
);
	import rxals_pkg::*;

	logic [INTERVAL_W-1:0] word_count;
	logic first_seen;
	logic [CONSEC_W-1:0] consec;

	wire marker_now = word_valid_i && marker_i;
	// first marker has no reference spacing, so it cannot be mistimed
	wire mistimed = first_seen && (word_count != marker_interval_minus_one_i);
	wire marker_err = marker_now && (marker_bad_i || mistimed);
	wire marker_good = marker_now && !marker_err;
	wire count_sat = &word_count;
	wire [CONSEC_W-1:0] next_consec = marker_good ? '0 :
		(marker_err && consec != REPEAT_LIMIT) ? consec + 3'h1 : consec;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_count <= '0;
			first_seen <= 1'b0;
			consec <= '0;
			lane_marker_repeat_error_o <= 1'b0;
			lane_marker_word_error_o <= 1'b0;
			bip_error_o <= 1'b0;
			marker_error_o <= 1'b0;
			marker_good_seen_o <= 1'b0;
			locked_o <= 1'b0;
		end else begin
			if (marker_now) begin
				word_count <= '0;
				first_seen <= 1'b1;
			end else if (word_valid_i && !count_sat) begin
				word_count <= word_count + 16'h0001;
			end
			consec <= next_consec;
			// level until a good marker breaks the run
			lane_marker_repeat_error_o <= (next_consec == REPEAT_LIMIT);
			lane_marker_word_error_o <= marker_now && marker_bad_i;
			bip_error_o <= marker_now && bip_mismatch_i;
			marker_error_o <= marker_err;
			if (marker_good) begin
				marker_good_seen_o <= 1'b1;
			end
			locked_o <= (marker_good_seen_o || marker_good) && (next_consec != REPEAT_LIMIT);
		end
	end

endmodule

`default_nettype wire

// file: src/rxals_top.sv
// Overview of operation
// - four consecutive marker errors raise lane repeat flag
// - malformed marker word pulses lane word error
// - misaligned pulse one metaframe after bad marker
// - no misaligned pulse before every lane has seen a good marker with deskew done
// - alignment-loss level high when unaligned or lost
// - lane parity mismatch pulses lane parity error
// - aligned high only when all lanes deskewed
// - high error rate flag follows rate monitor
// - link status is aligned and not high error
// - two-bit code-violation increment on decode error
// - valid strobe qualifies code-violation increment
// - eight-bit pattern mismatch increment only when enabled
// - valid strobe qualifies pattern mismatch increment
// - markers not spaced by interval count are errors
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module rxals_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [rxals_pkg::ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	// lane aligner events
	input wire logic [rxals_pkg::LANES-1:0] lane_word_valid_i,
	input wire logic [rxals_pkg::LANES-1:0] lane_marker_i,
	input wire logic [rxals_pkg::LANES-1:0] lane_marker_bad_i,
	input wire logic [rxals_pkg::LANES-1:0] lane_bip_mismatch_i,
	input wire logic deskew_done_i,
	input wire logic align_fail_i,
	// decoder, error rate monitor and pattern checker
	input wire logic ber_exceeded_i,
	input wire logic decode_valid_i,
	input wire logic [rxals_pkg::BAD_CODE_W-1:0] decode_error_count_i,
	input wire logic pattern_valid_i,
	input wire logic [rxals_pkg::TP_ERR_W-1:0] pattern_mismatch_count_i,
	// lane status
	output logic [rxals_pkg::LANES-1:0] lane_marker_repeat_error_o,
	output logic [rxals_pkg::LANES-1:0] lane_marker_word_error_o,
	output logic [rxals_pkg::LANES-1:0] bip_error_o,
	// alignment and link status
	output logic misaligned_o,
	output logic alignment_lost_o,
	output logic aligned_o,
	output logic high_error_rate_flag_o,
	output logic link_status_o,
	// increments
	output logic [rxals_pkg::BAD_CODE_W-1:0] bad_code_o,
	output logic bad_code_valid_o,
	output logic [rxals_pkg::TP_ERR_W-1:0] pattern_error_o,
	output logic pattern_error_valid_o
);
	import rxals_pkg::*;

	// control registers
	logic [INTERVAL_W-1:0] marker_interval_minus_one;
	logic test_pattern_enable;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;

	// lane results
	logic [LANES-1:0] lane_marker_error;
	logic [LANES-1:0] lane_good_seen;
	logic [LANES-1:0] lane_locked;

	// misalignment tracker
	rxals_track_type track;
	rxals_track_type next_track;
	logic [INTERVAL_W-1:0] mf_count;
	logic ever_aligned;
	logic aligned_prev;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : lane_gen
			rxals_lane u_lane (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.word_valid_i(lane_word_valid_i[g]),
				.marker_i(lane_marker_i[g]),
				.marker_bad_i(lane_marker_bad_i[g]),
				.bip_mismatch_i(lane_bip_mismatch_i[g]),
				.marker_interval_minus_one_i(marker_interval_minus_one),
				.lane_marker_repeat_error_o(lane_marker_repeat_error_o[g]),
				.lane_marker_word_error_o(lane_marker_word_error_o[g]),
				.bip_error_o(bip_error_o[g]),
				.marker_error_o(lane_marker_error[g]),
				.marker_good_seen_o(lane_good_seen[g]),
				.locked_o(lane_locked[g])
			);
		end
	endgenerate

	// alignment decode
	wire all_locked = &lane_locked;
	wire next_aligned = all_locked && deskew_done_i && !align_fail_i;
	wire all_seen_once = (&lane_good_seen) && deskew_done_i;
	wire any_marker_error = |lane_marker_error;
	// one metaframe counted on lane 0 words, interval plus the marker itself
	wire mf_tick = lane_word_valid_i[0];
	wire mf_done = mf_tick && (mf_count == '0);
	wire next_misaligned = (track == RXALS_PENDING) && mf_done;

	// misalignment tracker: a new error while pending and before mf_done merges into the pending pulse
	always_comb begin
		next_track = track;
		unique case (track)
			RXALS_NEVER: begin
				if (all_seen_once) begin
					next_track = RXALS_ARMED;
				end
			end
			RXALS_ARMED: begin
				if (any_marker_error) begin
					next_track = RXALS_PENDING;
				end
			end
			RXALS_PENDING: begin
				if (mf_done) begin
					next_track = any_marker_error ? RXALS_PENDING : RXALS_ARMED;
				end
			end
			default: begin
				next_track = RXALS_NEVER;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			track <= RXALS_NEVER;
			mf_count <= '0;
		end else begin
			track <= next_track;
			if (next_track == RXALS_PENDING && (track != RXALS_PENDING || mf_done)) begin
				mf_count <= marker_interval_minus_one;
			end else if (track == RXALS_PENDING && mf_tick) begin
				mf_count <= mf_count - 16'h0001;
			end
		end
	end

	// registered status outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			misaligned_o <= 1'b0;
			aligned_o <= 1'b0;
			aligned_prev <= 1'b0;
			alignment_lost_o <= 1'b1;
			high_error_rate_flag_o <= 1'b0;
			link_status_o <= 1'b0;
			ever_aligned <= 1'b0;
		end else begin
			misaligned_o <= next_misaligned;
			aligned_o <= next_aligned;
			aligned_prev <= aligned_o;
			// unaligned covers both a failed first alignment and a later loss
			alignment_lost_o <= !next_aligned;
			high_error_rate_flag_o <= ber_exceeded_i;
			link_status_o <= next_aligned && !ber_exceeded_i;
			if (track != RXALS_NEVER) begin
				ever_aligned <= 1'b1;
			end
		end
	end

	// increments: zero whenever not qualified, so a careless consumer still counts right
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bad_code_o <= '0;
			bad_code_valid_o <= 1'b0;
			pattern_error_o <= '0;
			pattern_error_valid_o <= 1'b0;
		end else begin
			bad_code_o <= decode_valid_i ? decode_error_count_i : '0;
			bad_code_valid_o <= decode_valid_i;
			pattern_error_o <= (test_pattern_enable && pattern_valid_i) ? pattern_mismatch_count_i : '0;
			pattern_error_valid_o <= test_pattern_enable && pattern_valid_i;
		end
	end

	// wishbone decode
	wire req = cyc_i && stb_i && !ack_o;
	wire wr = req && we_i;
	wire hit_ctrl = (adr_i == CTRL_OFS);
	wire hit_status = (adr_i == STATUS_OFS);
	wire hit_irq_status = (adr_i == IRQ_STATUS_OFS);
	wire hit_irq_mask = (adr_i == IRQ_MASK_OFS);

	wire [31:0] ctrl_word = {15'h0000, test_pattern_enable, marker_interval_minus_one};
	wire [31:0] status_word = {16'h0000, lane_locked, lane_marker_repeat_error_o, 3'h0, ever_aligned,
		alignment_lost_o, link_status_o, high_error_rate_flag_o, aligned_o};
	wire [31:0] read_word = hit_ctrl ? ctrl_word :
		hit_status ? status_word :
		hit_irq_status ? {26'h0000000, irq_status} :
		hit_irq_mask ? {26'h0000000, irq_mask} : 32'h00000000;

	// interrupt events
	wire [IRQ_W-1:0] irq_event;
	assign irq_event[IRQ_MISALIGN_BIT] = misaligned_o;
	assign irq_event[IRQ_BIP_BIT] = |bip_error_o;
	assign irq_event[IRQ_MARKER_WORD_BIT] = |lane_marker_word_error_o;
	assign irq_event[IRQ_BAD_CODE_BIT] = bad_code_valid_o && (bad_code_o != '0);
	assign irq_event[IRQ_TP_ERR_BIT] = pattern_error_valid_o && (pattern_error_o != '0);
	assign irq_event[IRQ_ALIGN_LOSS_BIT] = aligned_prev && !aligned_o;
	wire [IRQ_W-1:0] irq_clear = (wr && hit_irq_status && sel_i[0]) ? dat_i[IRQ_W-1:0] : '0;
	// a new event in the clearing cycle wins over the clear
	wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_event;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end else begin
			ack_o <= req;
			dat_o <= req ? read_word : 32'h00000000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			marker_interval_minus_one <= INTERVAL_RESET;
			test_pattern_enable <= CTRL_TP_EN_RESET;
			irq_mask <= IRQ_MASK_RESET;
			irq_status <= '0;
			irq_o <= 1'b0;
		end else begin
			if (wr && hit_ctrl && sel_i[0]) begin
				marker_interval_minus_one[7:0] <= dat_i[CTRL_INTERVAL_LSB +: 8];
			end
			if (wr && hit_ctrl && sel_i[1]) begin
				marker_interval_minus_one[15:8] <= dat_i[CTRL_INTERVAL_LSB + 8 +: 8];
			end
			if (wr && hit_ctrl && sel_i[2]) begin
				test_pattern_enable <= dat_i[CTRL_TP_EN_BIT];
			end
			if (wr && hit_irq_mask && sel_i[0]) begin
				irq_mask <= dat_i[IRQ_W-1:0];
			end
			irq_status <= next_irq_status;
			irq_o <= |(next_irq_status & irq_mask);
		end
	end

endmodule

`default_nettype wire

// file: test/rxals_chk.sv
`timescale 1ns/1ns
`default_nettype none
module rxals_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// watched inputs
	input wire logic [3:0] lane_word_valid_i,
	input wire logic [3:0] lane_marker_i,
	input wire logic [3:0] lane_marker_bad_i,
	input wire logic [3:0] lane_bip_mismatch_i,
	input wire logic deskew_done_i,
	input wire logic align_fail_i,
	input wire logic ber_exceeded_i,
	input wire logic decode_valid_i,
	input wire logic [1:0] decode_error_count_i,
	// watched outputs
	input wire logic [3:0] lane_marker_word_error_o,
	input wire logic [3:0] bip_error_o,
	input wire logic misaligned_o,
	input wire logic alignment_lost_o,
	input wire logic aligned_o,
	input wire logic high_error_rate_flag_o,
	input wire logic link_status_o,
	input wire logic [1:0] bad_code_o,
	input wire logic bad_code_valid_o,
	input wire logic [7:0] pattern_error_o,
	input wire logic pattern_error_valid_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// superset of lanes with a good marker, so the check never fires early
	logic [3:0] seen;
	always_ff @(posedge clk_i) begin
		if (rst_i) seen <= 4'h0;
		else seen <= seen | (lane_word_valid_i & lane_marker_i & ~lane_marker_bad_i);
	end
	chk_word_err_pulse: assert property (!$past(rst_i) |-> lane_marker_word_error_o ==
		$past(lane_word_valid_i & lane_marker_i & lane_marker_bad_i)) else $error("word error pulse wrong");
	chk_bip_err_pulse: assert property (!$past(rst_i) |-> bip_error_o ==
		$past(lane_word_valid_i & lane_marker_i & lane_bip_mismatch_i)) else $error("parity pulse wrong");
	chk_no_early_misalign: assert property (misaligned_o |-> &seen) else $error("early misalign");
	chk_loss_level: assert property (aligned_o |-> !alignment_lost_o) else $error("loss while aligned");
	chk_aligned_cause: assert property ($rose(aligned_o) |->
		$past(deskew_done_i && !align_fail_i)) else $error("aligned without deskew");
	chk_ber_follow: assert property (!$past(rst_i) |->
		high_error_rate_flag_o == $past(ber_exceeded_i)) else $error("high error flag wrong");
	chk_link_status: assert property (link_status_o ==
		(aligned_o && !high_error_rate_flag_o)) else $error("link status wrong");
	chk_code_inc: assert property (!$past(rst_i) |-> (bad_code_valid_o == $past(decode_valid_i)) &&
		(bad_code_o == ($past(decode_valid_i) ? $past(decode_error_count_i) : 2'h0))) else $error("code inc wrong");
	chk_pattern_quiet: assert property (!pattern_error_valid_o |->
		pattern_error_o == 8'h00) else $error("pattern inc without strobe");
endmodule
bind rxals_top rxals_chk u_chk (.*);
`default_nettype wire

// file: test/rxals_stats.sv
`timescale 1ns/1ns
`default_nettype none
module rxals_stats (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// increments
	input wire logic [1:0] bad_code_i,
	input wire logic bad_code_valid_i,
	input wire logic [7:0] pattern_error_i,
	input wire logic pattern_error_valid_i,
	// totals
	output var int bad_total_o,
	output var int pattern_total_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bad_total_o <= 0;
			pattern_total_o <= 0;
		end else begin
			if (bad_code_valid_i) bad_total_o <= bad_total_o + int'(bad_code_i);
			if (pattern_error_valid_i) pattern_total_o <= pattern_total_o + int'(pattern_error_i);
		end
	end
endmodule
`default_nettype wire

// file: test/rxals_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module rxals_top_test;
	import rxals_pkg::*;
	localparam int N = 3;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o, irq_o;
	logic [3:0] adr_i = 4'h0, sel_i = 4'h0, lane_word_valid_i = 4'hF, lane_marker_i = 4'h0;
	logic [3:0] lane_marker_bad_i = 4'h0, lane_bip_mismatch_i = 4'h0;
	logic [3:0] lane_marker_repeat_error_o, lane_marker_word_error_o, bip_error_o;
	logic [31:0] dat_i = 32'h0, dat_o, rd;
	logic deskew_done_i = 1'b1, align_fail_i = 1'b0, ber_exceeded_i = 1'b0, decode_valid_i = 1'b0;
	logic pattern_valid_i = 1'b0, misaligned_o, alignment_lost_o, aligned_o, high_error_rate_flag_o;
	logic link_status_o, bad_code_valid_o, pattern_error_valid_o, al;
	logic [1:0] decode_error_count_i = 2'h0, bad_code_o;
	logic [7:0] pattern_mismatch_count_i = 8'h0, pattern_error_o;
	int failures = 0, check_count = 0, mis_n = 0, wcnt = -1, bsum = 0, psum = 0, btot, ptot;
	int consec[4] = '{0, 0, 0, 0}, seen[4] = '{0, 0, 0, 0};
	rxals_top u_dut (.*);
	rxals_stats u_stats (.clk_i(clk_i), .rst_i(rst_i), .bad_code_i(bad_code_o), .bad_code_valid_i(bad_code_valid_o),
		.pattern_error_i(pattern_error_o), .pattern_error_valid_i(pattern_error_valid_o),
		.bad_total_o(btot), .pattern_total_o(ptot));
	initial forever #20 clk_i = ~clk_i;
	// words since the last marker; -1 until the first one
	always @(posedge clk_i) begin
		if (|lane_marker_i) wcnt <= 0;
		else if (wcnt >= 0) wcnt <= wcnt + 1;
		if (misaligned_o === 1'b1) mis_n++;
	end
	task automatic chk(input string what, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [3:0] a, s, input logic [31:0] d, output logic [31:0] q);
		int t;
		// start every request on a rising edge, never a few nanoseconds after it
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 20);
		chk("ack", 1, ack_o);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// one marker on all lanes, then len plain words; the model tracks error runs per lane
	task automatic frame(input logic [3:0] bad, bip, input int len);
		logic [3:0] rep;
		lane_marker_i <= 4'hF;
		lane_marker_bad_i <= bad;
		lane_bip_mismatch_i <= bip;
		@(posedge clk_i);
		lane_marker_i <= 4'h0;
		lane_marker_bad_i <= 4'h0;
		lane_bip_mismatch_i <= 4'h0;
		al = deskew_done_i & !align_fail_i;
		for (int l = 0; l < 4; l++) begin
			if (bad[l] || (wcnt >= 0 && wcnt != N)) consec[l]++;
			else begin
				consec[l] = 0;
				seen[l] = 1;
			end
			rep[l] = consec[l] >= 4;
			al &= seen[l] && !rep[l];
		end
		#1;
		chk("word_error", bad, lane_marker_word_error_o);
		chk("bip_error", bip, bip_error_o);
		chk("repeat_error", rep, lane_marker_repeat_error_o);
		repeat (len) @(posedge clk_i);
		#1;
		chk("aligned", al, aligned_o);
		chk("align_loss", !al, alignment_lost_o);
		chk("high_error", ber_exceeded_i, high_error_rate_flag_o);
		chk("link", al & !ber_exceeded_i, link_status_o);
	endtask
	task automatic incs(input logic en);
		logic dv, pv;
		logic [1:0] dc;
		logic [7:0] pc;
		for (int i = 0; i < 12; i++) begin
			dv = 1'($urandom);
			pv = 1'($urandom);
			dc = 2'($urandom);
			pc = 8'($urandom);
			decode_valid_i <= dv;
			decode_error_count_i <= dc;
			pattern_valid_i <= pv;
			pattern_mismatch_count_i <= pc;
			@(posedge clk_i);
			#1;
			bsum += dv ? dc : 0;
			psum += (en && pv) ? pc : 0;
			chk("bad_code", {dv, dv ? dc : 2'h0}, {bad_code_valid_o, bad_code_o});
			chk("pattern", {en & pv, (en && pv) ? pc : 8'h0}, {pattern_error_valid_o, pattern_error_o});
		end
		decode_valid_i <= 1'b0;
		pattern_valid_i <= 1'b0;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		failures++;
		report_and_stop();
	end
	initial begin
		void'($urandom(34));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("reset", 8'h04, {lane_marker_repeat_error_o, misaligned_o, alignment_lost_o, aligned_o, link_status_o});
		wb(1'b0, CTRL_OFS, 4'hF, 32'h0, rd);
		chk("ctrl_reset", 32'h000000FF, rd);
		wb(1'b0, 4'h2, 4'hF, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, CTRL_OFS, 4'h3, N, rd);
		frame(4'h1, 4'h0, N);
		repeat (3) frame(4'h0, 4'h0, N);
		chk("no_early_misalign", 0, mis_n);
		frame(4'h2, 4'h0, N);
		repeat (2) frame(4'h0, 4'h0, N);
		chk("misalign_once", 1, mis_n);
		frame(4'h0, 4'h9, N);
		ber_exceeded_i <= 1'b1;
		frame(4'h0, 4'h0, N);
		ber_exceeded_i <= 1'b0;
		align_fail_i <= 1'b1;
		frame(4'h0, 4'h0, N);
		align_fail_i <= 1'b0;
		for (int i = 0; i < 6; i++) frame(4'h0, 4'h0, (i < 4) ? N + 1 : N);
		repeat (4) frame(4'h4, 4'h0, N);
		frame(4'h0, 4'h0, N);
		incs(1'b0);
		wb(1'b1, CTRL_OFS, 4'h4, 32'h00010000, rd);
		incs(1'b1);
		wb(1'b1, IRQ_STATUS_OFS, 4'h1, 32'h3F, rd);
		wb(1'b1, IRQ_MASK_OFS, 4'h1, 32'h2, rd);
		chk("irq_idle", 1'b0, irq_o);
		frame(4'h0, 4'h2, N);
		chk("irq_set", 1'b1, irq_o);
		wb(1'b0, IRQ_STATUS_OFS, 4'h1, 32'h0, rd);
		chk("irq_status", 1'b1, rd[1]);
		wb(1'b1, IRQ_STATUS_OFS, 4'h1, 32'h2, rd);
		chk("irq_clear", 1'b0, irq_o);
		chk("bad_total", bsum, btot);
		chk("pattern_total", psum, ptot);
		report_and_stop();
	end
endmodule
`default_nettype wire
